// *** logic/category_a_fault_protection.sv ***
// Category A protection: Vce and overcurrent sensing, enable monitor,
// output stage sequencing, blanking select watchdog, AXI4-Lite registers.
// Assumes comparator and pwm inputs synchronous to clk_sys_in.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module category_a_fault_protection #(
    parameter int WD_LIMIT = fault_prot_pkg::WD_CYCLES
) (
    input  wire logic                                clk_sys_in,
    input  wire logic                                nrst_in,
    input  wire logic [fault_prot_pkg::ADDR_W-1:0]   s_axi_awaddr_in,
    input  wire logic                                s_axi_awvalid_in,
    output logic                                     s_axi_awready_out,
    input  wire logic [fault_prot_pkg::DATA_W-1:0]   s_axi_wdata_in,
    input  wire logic [3:0]                          s_axi_wstrb_in,
    input  wire logic                                s_axi_wvalid_in,
    output logic                                     s_axi_wready_out,
    output logic [1:0]                               s_axi_bresp_out,
    output logic                                     s_axi_bvalid_out,
    input  wire logic                                s_axi_bready_in,
    input  wire logic [fault_prot_pkg::ADDR_W-1:0]   s_axi_araddr_in,
    input  wire logic                                s_axi_arvalid_in,
    output logic                                     s_axi_arready_out,
    output logic [fault_prot_pkg::DATA_W-1:0]        s_axi_rdata_out,
    output logic [1:0]                               s_axi_rresp_out,
    output logic                                     s_axi_rvalid_out,
    input  wire logic                                s_axi_rready_in,
    input  wire logic                                pwm_in,
    input  wire logic                                vce_sense_in,
    input  wire logic                                overcurrent_sense_input_in,
    input  wire logic                                en_valid_in,
    input  wire logic                                class_b_event_in,
    output logic                                     gate_on_out,
    output logic                                     two_level_turnoff_out,
    output logic                                     vce_sense_pull_low_out,
    output logic                                     clamp_release_busy_out,
    output logic                                     fault_notify_a_n_out,
    output logic                                     disabled_out
);
    import fault_prot_pkg::*;

    localparam int              WD_W    = $clog2(WD_LIMIT + 1);
    localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_LIMIT - 1);

    typedef enum logic [1:0] {STAGE_OFF, STAGE_ON, STAGE_PLATEAU} stage_t;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= OFS_REL_DLY);
    endfunction

    function automatic logic [TIME_W:0] widen(input logic [TIME_W-1:0] v);
        widen = {1'b0, v};
    endfunction

    // Bus state
    logic                   aw_got_r;
    logic [ADDR_W-1:0]      aw_addr_r;
    logic                   w_got_r;
    logic [DATA_W-1:0]      w_data_r;
    logic [3:0]             w_strb_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [DATA_W-1:0]      rdata_r;
    logic [1:0]             rresp_r;
    logic                   do_write;
    logic                   wr_lane0;
    // Software registers
    logic                   req_r;
    logic                   refresh_r;
    logic                   clamp_en_r;
    logic [TIME_W-1:0]      blank0_r;
    logic [TIME_W-1:0]      blank1_r;
    logic [TIME_W-1:0]      ocp_blank_r;
    logic [TIME_W-1:0]      plateau_r;
    logic [TIME_W-1:0]      rel_dly_r;
    logic [ERR_W-1:0]       err_r;
    logic [ERR_W-1:0]       err_set;
    logic [ERR_W-1:0]       err_clr;
    logic                   reactivate_pls;
    logic                   reinit_pls;
    // Secondary side
    logic                   req_m_r;
    logic                   ref_m_r;
    logic                   ref_m_prev_r;
    logic                   sel_r;
    logic                   wd_hold_r;
    logic [WD_W-1:0]        wd_cnt_r;
    logic                   ref_rise;
    logic                   wd_timeout;
    // Output stage
    stage_t                 st_r;
    logic [TIME_W-1:0]      on_cnt_r;
    logic [TIME_W:0]        off_cnt_r;
    logic [TIME_W:0]        off_len;
    logic [TIME_W-1:0]      rel_cnt_r;
    logic [TIME_W-1:0]      active_blank;
    logic                   blank_done;
    logic                   ocp_done;
    logic                   desat_trip;
    logic                   ocp_trip;
    logic                   safe_trip;
    logic                   en_prev_r;
    logic                   en_fall;
    logic                   regular_trip;
    logic                   go_off;
    logic                   go_on;
    logic                   disabled_r;
    logic                   classb_lock_r;
    logic                   ocp_status;
    logic [DATA_W-1:0]      status_word;

    // AXI4-Lite write channels
    assign s_axi_awready_out = !aw_got_r && !bvalid_r;
    assign s_axi_wready_out  = !w_got_r && !bvalid_r;
    assign do_write          = aw_got_r && w_got_r && !bvalid_r;
    assign wr_lane0          = do_write && w_strb_r[0];
    assign s_axi_bvalid_out  = bvalid_r;
    assign s_axi_bresp_out   = bresp_r;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_got_r  <= 1'b0;
            aw_addr_r <= '0;
            w_got_r   <= 1'b0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata_in;
                w_strb_r <= s_axi_wstrb_in;
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready_in) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Register writes
    assign reactivate_pls = wr_lane0 && aw_addr_r == OFS_CTRL && w_data_r[CTRL_REACT];
    assign reinit_pls     = wr_lane0 && aw_addr_r == OFS_CTRL && w_data_r[CTRL_REINIT];

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_r       <= 1'b0;
            refresh_r   <= 1'b0;
            clamp_en_r  <= 1'b0;
            blank0_r    <= RST_BLANK;
            blank1_r    <= RST_BLANK;
            ocp_blank_r <= RST_OCP_BLANK;
            plateau_r   <= RST_PLATEAU;
            rel_dly_r   <= RST_REL_DLY;
        end else if (wr_lane0) begin
            unique case (aw_addr_r)
                OFS_CTRL: begin
                    req_r      <= w_data_r[CTRL_REQ];
                    refresh_r  <= w_data_r[CTRL_REFRESH];
                    clamp_en_r <= w_data_r[CTRL_CLAMP_EN];
                end
                OFS_BLANK0:    blank0_r    <= w_data_r[TIME_W-1:0];
                OFS_BLANK1:    blank1_r    <= w_data_r[TIME_W-1:0];
                OFS_OCP_BLANK: ocp_blank_r <= w_data_r[TIME_W-1:0];
                OFS_PLATEAU:   plateau_r   <= w_data_r[TIME_W-1:0];
                OFS_REL_DLY:   rel_dly_r   <= w_data_r[TIME_W-1:0];
                default: ;
            endcase
        end
    end

    // Error flags: hardware set wins over software clear
    assign err_set = {class_b_event_in, wd_timeout, en_fall, ocp_trip, desat_trip};
    assign err_clr = (wr_lane0 && aw_addr_r == OFS_ERR) ? w_data_r[ERR_W-1:0] : '0;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            err_r <= '0;
        end else begin
            err_r <= (err_r & ~err_clr) | err_set;
        end
    end

    // AXI4-Lite read channel
    assign ocp_status  = overcurrent_sense_input_in && !(st_r == STAGE_ON && !ocp_done);
    assign status_word = DATA_W'({gate_on_out, classb_lock_r, disabled_r, sel_r,
                                  en_valid_in, ocp_status, vce_sense_in});
    assign s_axi_arready_out = !rvalid_r;
    assign s_axi_rvalid_out  = rvalid_r;
    assign s_axi_rdata_out   = rdata_r;
    assign s_axi_rresp_out   = rresp_r;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_r <= 1'b1;
            rresp_r  <= is_mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr_in)
                OFS_CTRL:      rdata_r <= DATA_W'({clamp_en_r, refresh_r, req_r});
                OFS_STATUS:    rdata_r <= status_word;
                OFS_ERR:       rdata_r <= DATA_W'(err_r);
                OFS_BLANK0:    rdata_r <= DATA_W'(blank0_r);
                OFS_BLANK1:    rdata_r <= DATA_W'(blank1_r);
                OFS_OCP_BLANK: rdata_r <= DATA_W'(ocp_blank_r);
                OFS_PLATEAU:   rdata_r <= DATA_W'(plateau_r);
                OFS_REL_DLY:   rdata_r <= DATA_W'(rel_dly_r);
                default:       rdata_r <= '0;
            endcase
        end else if (rvalid_r && s_axi_rready_in) begin
            rvalid_r <= 1'b0;
        end
    end

    // Blanking select with refresh watchdog
    assign ref_rise   = ref_m_r && !ref_m_prev_r;
    assign wd_timeout = sel_r && req_m_r && wd_cnt_r == WD_LAST && !ref_rise;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_m_r      <= 1'b0;
            ref_m_r      <= 1'b0;
            ref_m_prev_r <= 1'b0;
        end else begin
            req_m_r      <= req_r;
            ref_m_r      <= refresh_r;
            ref_m_prev_r <= ref_m_r;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sel_r     <= 1'b0;
            wd_hold_r <= 1'b0;
        end else begin
            if (!req_m_r || wd_timeout || reinit_pls) begin
                sel_r <= 1'b0;
            end else if (ref_m_r && !wd_hold_r) begin
                sel_r <= 1'b1;
            end
            if (wd_timeout) begin
                wd_hold_r <= 1'b1;
            end else if (!ref_m_r || !req_m_r) begin
                wd_hold_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wd_cnt_r <= '0;
        end else if (!sel_r || ref_rise) begin
            wd_cnt_r <= '0;
        end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
        end
    end

    // Trip detection
    assign active_blank = sel_r ? blank1_r : blank0_r;
    assign blank_done   = on_cnt_r >= active_blank;
    assign ocp_done     = (ocp_blank_r == '0) || (on_cnt_r >= ocp_blank_r);
    assign desat_trip   = st_r == STAGE_ON && blank_done && vce_sense_in;
    assign ocp_trip     = st_r == STAGE_ON && ocp_done && overcurrent_sense_input_in;
    assign safe_trip    = desat_trip || ocp_trip;
    assign en_fall      = en_prev_r && !en_valid_in;
    assign regular_trip = en_fall || class_b_event_in;
    assign go_off       = st_r == STAGE_ON && (!pwm_in || disabled_r || safe_trip || regular_trip);
    assign go_on        = st_r == STAGE_OFF && pwm_in && !disabled_r && !regular_trip;
    assign off_len      = widen(plateau_r)
                        + ((active_blank < BLANK_EXT_LIMIT) ? widen(active_blank) : '0);

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            en_prev_r <= 1'b0;
        end else begin
            en_prev_r <= en_valid_in;
        end
    end

    // Disable and reactivation
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            disabled_r    <= 1'b0;
            classb_lock_r <= 1'b0;
        end else begin
            if (class_b_event_in) begin
                classb_lock_r <= 1'b1;
            end else if (reinit_pls) begin
                classb_lock_r <= 1'b0;
            end
            if (safe_trip || regular_trip) begin
                disabled_r <= 1'b1;
            end else if (reactivate_pls && !classb_lock_r) begin
                disabled_r <= 1'b0;
            end
        end
    end

    // Output stage sequencing
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r      <= STAGE_OFF;
            on_cnt_r  <= '0;
            off_cnt_r <= '0;
        end else begin
            unique case (st_r)
                STAGE_OFF: begin
                    on_cnt_r <= '0;
                    if (go_on) begin
                        st_r <= STAGE_ON;
                    end
                end
                STAGE_ON: begin
                    if (on_cnt_r != '1) begin
                        on_cnt_r <= on_cnt_r + 1'b1;
                    end
                    if (go_off) begin
                        st_r      <= STAGE_PLATEAU;
                        off_cnt_r <= '0;
                    end
                end
                STAGE_PLATEAU: begin
                    off_cnt_r <= off_cnt_r + 1'b1;
                    if (off_cnt_r + 1'b1 >= off_len) begin
                        st_r <= STAGE_OFF;
                    end
                end
            endcase
        end
    end

    // Clamp release delay after regular turn-off only
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rel_cnt_r <= '0;
        end else if (go_off) begin
            rel_cnt_r <= safe_trip ? '0 : rel_dly_r;
        end else if (rel_cnt_r != '0 && st_r == STAGE_OFF) begin
            rel_cnt_r <= rel_cnt_r - 1'b1;
        end
    end

    assign gate_on_out            = st_r == STAGE_ON;
    assign two_level_turnoff_out  = st_r == STAGE_PLATEAU && widen(plateau_r) > off_cnt_r;
    assign vce_sense_pull_low_out = (st_r == STAGE_ON && !blank_done)
                                  || st_r == STAGE_PLATEAU
                                  || (st_r == STAGE_OFF && clamp_en_r);
    assign clamp_release_busy_out = rel_cnt_r != '0;
    assign fault_notify_a_n_out   = !(err_r[ERR_VCE] || err_r[ERR_OCP] || err_r[ERR_EN]);
    assign disabled_out           = disabled_r;

    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    chk_trip_disables: assert property (safe_trip |=> disabled_r && st_r == STAGE_PLATEAU)
        else $error("trip did not disable stage");
    chk_classb_lock: assert property (classb_lock_r && !reinit_pls ##1 reactivate_pls
                                      |=> disabled_r)
        else $error("class B lock bypassed");
    chk_vce_idle_off: assert property (st_r != STAGE_ON |=> !$rose(err_r[ERR_VCE]))
        else $error("vce flag raised outside on state");
    chk_blank_pulldown: assert property (st_r == STAGE_ON && on_cnt_r < active_blank
                                         |-> vce_sense_pull_low_out && !desat_trip)
        else $error("sense pin released during blanking");
    chk_vce_react: assert property (desat_trip |=> err_r[ERR_VCE] && !fault_notify_a_n_out
                                    && st_r == STAGE_PLATEAU)
        else $error("vce trip reaction missing");
    chk_plateau_len: assert property (st_r == STAGE_PLATEAU && off_cnt_r + 1'b1 < off_len
                                      |=> st_r == STAGE_PLATEAU && vce_sense_pull_low_out)
        else $error("plateau ended early");
    chk_clamp_off: assert property (st_r == STAGE_OFF && clamp_en_r |-> vce_sense_pull_low_out)
        else $error("clamp missing while off");
    chk_safe_nodelay: assert property (safe_trip |=> !clamp_release_busy_out)
        else $error("release delay after safe off");
    chk_sel_set: assert property (req_m_r && ref_m_r && !wd_hold_r && !sel_r && !reinit_pls
                                  |=> sel_r)
        else $error("select status did not set");
    chk_sel_clear: assert property (!req_m_r |=> !sel_r)
        else $error("select status did not clear");
    chk_wd_timeout: assert property (sel_r && req_m_r && wd_cnt_r == WD_LAST && !ref_rise
                                     |=> !sel_r && err_r[ERR_TIMEOUT])
        else $error("watchdog timeout reaction missing");
    chk_wd_refresh: assert property (sel_r && ref_rise |=> wd_cnt_r == '0)
        else $error("refresh did not restart watchdog");
    chk_ocp_mask: assert property (st_r == STAGE_ON && !ocp_done |-> !ocp_status && !ocp_trip)
        else $error("overcurrent seen during blanking");
    chk_ocp_zero: assert property (st_r == STAGE_ON && ocp_blank_r == '0
                                   && overcurrent_sense_input_in |=> err_r[ERR_OCP])
        else $error("zero blanking did not trip at once");
    chk_en_fall: assert property (en_prev_r && !en_valid_in
                                  |=> err_r[ERR_EN] && !fault_notify_a_n_out && disabled_r)
        else $error("enable fault reaction missing");
    chk_fault_hold: assert property (err_r[ERR_OCP] |-> !fault_notify_a_n_out)
        else $error("fault pin released with flag set");

    cov_vce_trip: cover property (st_r == STAGE_ON ##1 desat_trip);
    cov_ocp_trip: cover property (ocp_trip);
    cov_wd_timeout: cover property (wd_timeout);
    cov_reactivate: cover property (disabled_r ##1 reactivate_pls ##1 !disabled_r);

endmodule

// *** include/fault_prot_pkg.sv ***
// What this block does
// - Class A event disables; fast reactivation resumes
// - Class B event disables; full reinit first
// - Vce check only during switch-on command
// - Hold sense pin low for active blanking
// - Vce trip: safe off, flag, fault pin
// - Live Vce comparator result readable
// - Turn-off pulldown plateau, plus blanking below 0x40
// - Clamp enable clamps pin while off
// - Safe turn-off skips clamp-release delay
// - Select status picks blanking register, mirrored
// - Host select and refresh bits mirrored
// - Select status sets on both mirrors set
// - Select status clears on request clear, timeout
// - Watchdog restarts on select rise, refresh rise
// - Watchdog overflow reverts select, sets flag
// - Overcurrent check only during switch-on command
// - Overcurrent evaluation inhibited during its blanking
// - Overcurrent status bit masked while blanking
// - Overcurrent trip: safe off, flag, fault pin
// - Enable invalid edge: regular off, flag, pin
// - Enable validity readable as status bit
// - Zero overcurrent blanking means immediate reaction
//
// Constants of the category A protection block.
// Assumes a 32-bit AXI4-Lite master and a 200 MHz system clock.
package fault_prot_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          TIME_W          = 8;
    // Register byte addresses
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_STATUS      = 8'h04;
    localparam logic [7:0]  OFS_ERR         = 8'h08;
    localparam logic [7:0]  OFS_BLANK0      = 8'h0C;
    localparam logic [7:0]  OFS_BLANK1      = 8'h10;
    localparam logic [7:0]  OFS_OCP_BLANK   = 8'h14;
    localparam logic [7:0]  OFS_PLATEAU     = 8'h18;
    localparam logic [7:0]  OFS_REL_DLY     = 8'h1C;
    // Control bits (write)
    localparam int          CTRL_REQ        = 0;
    localparam int          CTRL_REFRESH    = 1;
    localparam int          CTRL_CLAMP_EN   = 2;
    localparam int          CTRL_REACT      = 3;
    localparam int          CTRL_REINIT     = 4;
    // Status bits (read only)
    localparam int          ST_VCE_CMP      = 0;
    localparam int          ST_OCP_CMP      = 1;
    localparam int          ST_EN_VALID     = 2;
    localparam int          ST_SEL_MIRROR   = 3;
    localparam int          ST_DISABLED     = 4;
    localparam int          ST_CLASSB_LOCK  = 5;
    localparam int          ST_GATE_ON      = 6;
    // Error flags (write one to clear)
    localparam int          ERR_VCE         = 0;
    localparam int          ERR_OCP         = 1;
    localparam int          ERR_EN          = 2;
    localparam int          ERR_TIMEOUT     = 3;
    localparam int          ERR_CLASSB      = 4;
    localparam int          ERR_W           = 5;
    // Reset values
    localparam logic [7:0]  RST_BLANK       = 8'h20;
    localparam logic [7:0]  RST_OCP_BLANK   = 8'h10;
    localparam logic [7:0]  RST_PLATEAU     = 8'h08;
    localparam logic [7:0]  RST_REL_DLY     = 8'h04;
    localparam logic [7:0]  BLANK_EXT_LIMIT = 8'h40;
    // Timing
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          WD_TIMEOUT_NS   = 20000;
    localparam int          WD_CYCLES       = (WD_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// *** verif/host_model.sv ***
// Host model: AXI4-Lite master tasks for the protection block
// Assumes port names match the block so the bench wires it by name
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_sys_in, s_axi_awready_out, s_axi_wready_out,
    input  wire logic        s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out,
    input  wire logic [1:0]  s_axi_rresp_out, s_axi_bresp_out,
    input  wire logic [31:0] s_axi_rdata_out,
    output logic             s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in,
    output logic             s_axi_arvalid_in, s_axi_rready_in,
    output logic [7:0]       s_axi_awaddr_in, s_axi_araddr_in,
    output logic [31:0]      s_axi_wdata_in
);
    logic a, w, b;
    initial begin
        // Response readies stay high so back to back calls never toggle them
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h1;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h1;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
    end
    // Host writes select, refresh, reactivate and reinit bits
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr_in <= ad;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do begin
            @(negedge clk_sys_in);
            a = s_axi_awvalid_in && s_axi_awready_out;
            w = s_axi_wvalid_in && s_axi_wready_out;
            b = s_axi_bvalid_out;
            r = s_axi_bresp_out;
            @(posedge clk_sys_in);
            if (a) s_axi_awvalid_in <= 1'b0;
            if (w) s_axi_wvalid_in <= 1'b0;
        end while (!b);
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr_in <= ad;
        s_axi_arvalid_in <= 1'b1;
        do begin
            @(negedge clk_sys_in);
            a = s_axi_arvalid_in && s_axi_arready_out;
            b = s_axi_rvalid_out;
            d = s_axi_rdata_out;
            r = s_axi_rresp_out;
            @(posedge clk_sys_in);
            if (a) s_axi_arvalid_in <= 1'b0;
        end while (!b);
    endtask
endmodule

// *** verif/tb.sv ***
// Bench: trips, enable loss and select watchdog against fixed expected values
// Assumes host_model for register traffic
`timescale 1ns/1ps
module tb;
    import fault_prot_pkg::*;
    localparam int WD = 16;
    logic clk_sys_in = 1'b0, nrst_in = 1'b0, pwm_in = 1'b0, vce_sense_in = 1'b0;
    logic overcurrent_sense_input_in = 1'b0, en_valid_in = 1'b1, class_b_event_in = 1'b0;
    logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
    logic s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out, gate_on_out, two_level_turnoff_out;
    logic vce_sense_pull_low_out, clamp_release_busy_out, fault_notify_a_n_out, disabled_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rr;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rv;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    int mismatches = 0, samples_checked = 0, cyc = 0, n, seed = 32'ha11e2ff4, exp_err;
    category_a_fault_protection #(.WD_LIMIT(WD)) dut (.*);
    host_model host (.*);
    always #2.5 clk_sys_in = ~clk_sys_in;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic run_trip(input int k);
        exp_err = 1 << (k == 0 ? ERR_VCE : k == 1 ? ERR_OCP : ERR_EN);
        // Let the previous turn-off plateau finish before the next turn-on
        do @(negedge clk_sys_in); while (vce_sense_pull_low_out === 1'b1);
        @(posedge clk_sys_in);
        pwm_in <= 1'b1;
        overcurrent_sense_input_in <= (k == 1);
        repeat (30 * (k != 1)) begin
            @(posedge clk_sys_in);
            vce_sense_in <= 1'($random(seed));
            @(negedge clk_sys_in);
            chk("pull_low", 1, vce_sense_pull_low_out);
            chk("fault_n_blank", 1, fault_notify_a_n_out);
        end
        @(posedge clk_sys_in);
        vce_sense_in <= (k == 0);
        en_valid_in <= (k != 2);
        n = 0;
        while (fault_notify_a_n_out !== 1'b0 && n < 10) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk("fault_n", 0, fault_notify_a_n_out);
        chk("disabled", 1, disabled_out);
        chk("gate_on", 0, gate_on_out);
        chk("two_level", 1, two_level_turnoff_out);
        chk("release_busy", k == 2, clamp_release_busy_out);
        @(posedge clk_sys_in);
        {pwm_in, vce_sense_in, overcurrent_sense_input_in, en_valid_in} <= 4'h1;
        host.rd(OFS_ERR, rv, rr);
        chk("err", exp_err, rv);
        host.wr(OFS_ERR, 32'h1F, rr);
        @(negedge clk_sys_in);
        chk("fault_n_clear", 1, fault_notify_a_n_out);
        @(posedge clk_sys_in);
        host.wr(OFS_CTRL, 1 << CTRL_REACT, rr);
        host.rd(OFS_STATUS, rv, rr);
        chk("reactivated", 0, rv[ST_DISABLED]);
        chk("en_valid", 1, rv[ST_EN_VALID]);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(posedge clk_sys_in);
        host.wr(OFS_OCP_BLANK, 32'h0, rr);
        chk("bresp", RESP_OKAY, rr);
        vce_sense_in <= 1'b1;
        host.rd(OFS_STATUS, rv, rr);
        chk("vce_status", 1, rv[ST_VCE_CMP]);
        chk("fault_n_off", 1, fault_notify_a_n_out);
        for (int k = 0; k < 3; k++) run_trip(k);
        host.rd(8'h40, rv, rr);
        chk("unmapped", RESP_SLVERR, rr);
        host.wr(8'h40, 32'h0, rr);
        chk("unmapped_wr", RESP_SLVERR, rr);
        host.wr(OFS_CTRL, 3, rr);
        @(posedge clk_sys_in);
        host.rd(OFS_STATUS, rv, rr);
        chk("sel_set", 1, rv[ST_SEL_MIRROR]);
        repeat (WD + 4) @(posedge clk_sys_in);
        host.rd(OFS_ERR, rv, rr);
        chk("timeout", 1 << ERR_TIMEOUT, rv);
        host.rd(OFS_STATUS, rv, rr);
        chk("sel_clear", 0, rv[ST_SEL_MIRROR]);
        class_b_event_in <= 1'b1;
        @(posedge clk_sys_in);
        class_b_event_in <= 1'b0;
        host.wr(OFS_CTRL, 1 << CTRL_REACT, rr);
        host.rd(OFS_STATUS, rv, rr);
        chk("classb_lock", 32'h30, rv & 32'h30);
        host.wr(OFS_CTRL, 3 << CTRL_REACT, rr);
        host.wr(OFS_CTRL, 1 << CTRL_REACT, rr);
        host.rd(OFS_STATUS, rv, rr);
        chk("classb_reinit", 0, rv & 32'h30);
        finish_test();
    end
endmodule
